// ### cso_map.svh
`ifndef CSO_MAP_SVH
`define CSO_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CSO_ADDR_W          10
`define CSO_ADDR_THRESH_CFG 10'h01A
`define CSO_ADDR_STATUS     10'h01F
`define CSO_ADDR_DRV_CTRL   10'h0F0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CSO_THRESH_SEL_BIT  6
`define CSO_ST_CLK_BIT      3
`define CSO_ST_SREF_BIT     2
`define CSO_ST_FREF_BIT     1
`define CSO_ST_LOCK_BIT     0
`define CSO_FMT_BIT         7
`define CSO_LEG_HI          6
`define CSO_LEG_LO          5
`define CSO_LEG_B_BIT       6
`define CSO_LEG_A_BIT       5
`define CSO_POL_HI          4
`define CSO_POL_LO          3
`define CSO_SWING_HI        2
`define CSO_SWING_LO        1
`define CSO_PDN_BIT         0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CSO_THRESH_CFG_RST  8'h00
`define CSO_DRV_CTRL_RST    8'h62
`define CSO_STATUS_RST      8'h00

`endif

// ### cso_mon_if.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Monitor to register-file link
// ----------------------------------------------------------------
interface cso_mon_if;
   import cso_pkg::*;
   cso_status_type status;

   modport mon
   (
      output status
   );

   modport regs
   (
      input  status
   );
endinterface

// ### cso_pkg.sv
package cso_pkg;

   // Driver type selected by the format bit
   typedef enum logic
   {
      CSO_FMT_LVDS = 1'b0,
      CSO_FMT_CMOS = 1'b1
   } cso_fmt_type;

   // CMOS leg configuration field
   typedef enum logic [1:0]
   {
      CSO_LEGS_OFF  = 2'b00,
      CSO_LEG_A     = 2'b01,
      CSO_LEG_B     = 2'b10,
      CSO_LEGS_BOTH = 2'b11
   } cso_legs_type;

   // Monitor status as seen by the register file
   typedef struct packed
   {
      logic clk_above;
      logic second_ref_above;
      logic first_ref_above;
      logic digital_lock;
   } cso_status_type;

endpackage

// ### cso_regs.sv
// What this block does
// - Status bit 3 reads one when clock input exceeds monitor threshold.
// - Status bit 2 shows second reference above threshold set by 0x01A bit 6.
// - Status bit 1 shows first reference above the same selectable threshold.
// - Status bit 0 reads one while the PLL digital lock detector is locked.
// - Output control bit 7 selects driver: zero LVDS (default), one CMOS.
// - In CMOS, bits 6:5 pick legs: 00 none, 01 A, 10 B, 11 both.
`timescale 1ns/1ps
`include "cso_map.svh"

module cso_regs
   import cso_pkg::*;
(
   input  wire logic                   clk_in,
   input  wire logic                   reset_in,
   input  wire logic [`CSO_ADDR_W-1:0] reg_addr_in,
   input  wire logic                   reg_wr_in,
   input  wire logic                   reg_rd_in,
   input  wire logic [7:0]             reg_wdata_in,
   output logic      [7:0]             reg_rdata_out,
   output logic                        reg_rvalid_out,
   input  wire logic                   clk_above_thresh_in,
   input  wire logic                   first_ref_above_thresh_in,
   input  wire logic                   second_ref_above_thresh_in,
   input  wire logic                   pll_digital_lock_in,
   output logic                        ref_thresh_sel_out,
   output logic                        first_output_cmos_out,
   output logic                        first_output_leg_a_on_out,
   output logic                        first_output_leg_b_on_out,
   output logic      [1:0]             first_output_polarity_out,
   output logic      [1:0]             first_output_lvds_swing_out,
   output logic                        first_output_power_down_out
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   cso_mon_if  mon_link ();

   logic [7:0] thresh_cfg_r;
   logic [7:0] drv_ctrl_r;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic       rvalid_r;
   logic       cmos_r;
   logic       leg_a_r;
   logic       leg_b_r;
   logic       leg_a_nxt;
   logic       leg_b_nxt;

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------

   // Address match, shared by the write and read paths
   function automatic logic addr_hit(input logic [`CSO_ADDR_W-1:0] a,
                                     input logic [`CSO_ADDR_W-1:0] b);
      addr_hit = (a == b);
   endfunction

   // Pack monitor status into the readback byte; upper bits read zero
   function automatic logic [7:0] pack_status(input cso_status_type s);
      logic [7:0] v;
      v = 8'h00;
      v[`CSO_ST_CLK_BIT]  = s.clk_above;
      v[`CSO_ST_SREF_BIT] = s.second_ref_above;
      v[`CSO_ST_FREF_BIT] = s.first_ref_above;
      v[`CSO_ST_LOCK_BIT] = s.digital_lock;
      pack_status = v;
   endfunction

   // ----------------------------------------------------------------
   // Status monitor
   // ----------------------------------------------------------------
   cso_status_mon u_mon
   (
      .clk_in                     (clk_in),
      .reset_in                   (reset_in),
      .clk_above_thresh_in        (clk_above_thresh_in),
      .first_ref_above_thresh_in  (first_ref_above_thresh_in),
      .second_ref_above_thresh_in (second_ref_above_thresh_in),
      .pll_digital_lock_in        (pll_digital_lock_in),
      .mon                        (mon_link.mon)
   );

   // ----------------------------------------------------------------
   // Writable registers
   // ----------------------------------------------------------------

   // Threshold select; only bit 6 is implemented, the rest read zero
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         thresh_cfg_r <= `CSO_THRESH_CFG_RST;
      end
      else if (reg_wr_in && addr_hit(reg_addr_in, `CSO_ADDR_THRESH_CFG))
      begin
         thresh_cfg_r <= reg_wdata_in & (8'h01 << `CSO_THRESH_SEL_BIT);
      end
   end

   // First output channel driver control, all eight bits stored
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         drv_ctrl_r <= `CSO_DRV_CTRL_RST;
      end
      else if (reg_wr_in && addr_hit(reg_addr_in, `CSO_ADDR_DRV_CTRL))
      begin
         drv_ctrl_r <= reg_wdata_in;
      end
   end

   // Status offset has no storage, so a write there simply falls away
   // status writes dropped
   // (no write decode exists for the status offset)

   // ----------------------------------------------------------------
   // Driver leg decode
   // ----------------------------------------------------------------

   // LVDS drives both legs as one pair; leg field matters only in CMOS
   always_comb
   begin
      leg_a_nxt = 1'b1;
      leg_b_nxt = 1'b1;
      if (drv_ctrl_r[`CSO_FMT_BIT] == CSO_FMT_CMOS)
      begin
         case (cso_legs_type'(drv_ctrl_r[`CSO_LEG_HI:`CSO_LEG_LO]))
            CSO_LEGS_OFF:
            begin
               leg_a_nxt = 1'b0;
               leg_b_nxt = 1'b0;
            end
            CSO_LEG_A:
            begin
               leg_a_nxt = 1'b1;
               leg_b_nxt = 1'b0;
            end
            CSO_LEG_B:
            begin
               leg_a_nxt = 1'b0;
               leg_b_nxt = 1'b1;
            end
            default:
            begin
               leg_a_nxt = 1'b1;
               leg_b_nxt = 1'b1;
            end
         endcase
      end
   end

   // Registered so the pad controls never glitch on a decode change
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         cmos_r  <= CSO_FMT_LVDS;
         leg_a_r <= 1'b1;
         leg_b_r <= 1'b1;
      end
      else
      begin
         cmos_r  <= drv_ctrl_r[`CSO_FMT_BIT];
         leg_a_r <= leg_a_nxt;
         leg_b_r <= leg_b_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------

   // Read mux; unmapped offsets answer zero
   always_comb
   begin
      rdata_nxt = 8'h00;
      if (addr_hit(reg_addr_in, `CSO_ADDR_STATUS))
      begin
         rdata_nxt = pack_status(mon_link.status);
      end
      else if (addr_hit(reg_addr_in, `CSO_ADDR_THRESH_CFG))
      begin
         rdata_nxt = thresh_cfg_r;
      end
      else if (addr_hit(reg_addr_in, `CSO_ADDR_DRV_CTRL))
      begin
         rdata_nxt = drv_ctrl_r;
      end
   end

   // Read data held until the next read; valid follows the read strobe one cycle later
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         rdata_r  <= `CSO_STATUS_RST;
         rvalid_r <= 1'b0;
      end
      else
      begin
         rvalid_r <= reg_rd_in;
         if (reg_rd_in)
         begin
            rdata_r <= rdata_nxt;
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign reg_rdata_out               = rdata_r;
   assign reg_rvalid_out              = rvalid_r;
   assign ref_thresh_sel_out          = thresh_cfg_r[`CSO_THRESH_SEL_BIT];
   assign first_output_cmos_out       = cmos_r;
   assign first_output_leg_a_on_out   = leg_a_r;
   assign first_output_leg_b_on_out   = leg_b_r;
   assign first_output_polarity_out   = drv_ctrl_r[`CSO_POL_HI:`CSO_POL_LO];
   assign first_output_lvds_swing_out = drv_ctrl_r[`CSO_SWING_HI:`CSO_SWING_LO];
   assign first_output_power_down_out = drv_ctrl_r[`CSO_PDN_BIT];

endmodule

// ### cso_regs_asserts.sv
`timescale 1ns/1ps
`include "cso_map.svh"

module cso_regs_asserts
(
   input wire logic                   clk_in,
   input wire logic                   reset_in,
   input wire logic [`CSO_ADDR_W-1:0] reg_addr_in,
   input wire logic                   reg_wr_in,
   input wire logic                   reg_rd_in,
   input wire logic [7:0]             reg_wdata_in,
   input wire logic [7:0]             reg_rdata_out,
   input wire logic                   reg_rvalid_out,
   input wire logic                   clk_above_thresh_in,
   input wire logic                   first_ref_above_thresh_in,
   input wire logic                   second_ref_above_thresh_in,
   input wire logic                   pll_digital_lock_in,
   input wire logic                   ref_thresh_sel_out,
   input wire logic                   first_output_cmos_out,
   input wire logic                   first_output_leg_a_on_out,
   input wire logic                   first_output_leg_b_on_out,
   input wire logic [1:0]             first_output_polarity_out,
   input wire logic [1:0]             first_output_lvds_swing_out,
   input wire logic                   first_output_power_down_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   // Write strobes decoded for the driver control and status offsets
   wire wr_ctrl = reg_wr_in && reg_addr_in == `CSO_ADDR_DRV_CTRL;
   wire wr_stat = reg_wr_in && reg_addr_in == `CSO_ADDR_STATUS;
   wire [4:0] low_bits = {first_output_polarity_out, first_output_lvds_swing_out,
                          first_output_power_down_out};

   // ----------------------------------------------------------------
   // Register port checks
   // ----------------------------------------------------------------
   // Status lags the monitors by one sample, so compare two edges back
   status_read_a: assert property (
      reg_rvalid_out && $past(reg_addr_in) == `CSO_ADDR_STATUS && !$past(reset_in, 2)
      |-> reg_rdata_out == {4'h0, $past(clk_above_thresh_in, 2),
      $past(second_ref_above_thresh_in, 2), $past(first_ref_above_thresh_in, 2),
      $past(pll_digital_lock_in, 2)}) else $error("status readback wrong");
   rvalid_pulse_a: assert property (
      reg_rvalid_out == ($past(reg_rd_in) && !$past(reset_in))) else $error("rvalid wrong");
   thresh_write_a: assert property (
      reg_wr_in && reg_addr_in == `CSO_ADDR_THRESH_CFG
      |=> ref_thresh_sel_out == $past(reg_wdata_in[6])) else $error("threshold select wrong");
   format_write_a: assert property (
      wr_ctrl |-> ##2 first_output_cmos_out == $past(reg_wdata_in[7], 2))
      else $error("driver format wrong");
   legs_write_a: assert property (
      wr_ctrl |-> ##2 {first_output_leg_b_on_out, first_output_leg_a_on_out} ==
      ($past(reg_wdata_in[7], 2) ? $past(reg_wdata_in[6:5], 2) : 2'b11))
      else $error("leg enables wrong");
   lvds_legs_a: assert property (
      !first_output_cmos_out |-> first_output_leg_a_on_out && first_output_leg_b_on_out)
      else $error("legs off in LVDS");
   low_bits_a: assert property (wr_ctrl |=> low_bits == $past(reg_wdata_in[4:0]))
      else $error("direct fields wrong");
   reset_vals_a: assert property (
      $past(reset_in) |-> {first_output_cmos_out, first_output_leg_a_on_out,
      first_output_leg_b_on_out, ref_thresh_sel_out, low_bits} == 9'h0c2)
      else $error("reset values wrong");
   // Only register-direct outputs, legs may still settle from an older write
   ro_write_a: assert property (
      wr_stat |=> $stable({ref_thresh_sel_out, low_bits})) else $error("status write leaked");

   cover property (reg_rvalid_out && $past(reg_addr_in) == `CSO_ADDR_STATUS);
   cover property (wr_ctrl ##2 first_output_cmos_out);
   cover property (wr_stat);
endmodule

bind cso_regs cso_regs_asserts chk (.*);

// ### cso_regs_bench.sv
`timescale 1ns/1ps
`include "cso_map.svh"

module cso_regs_bench;
   logic                   clk_in = 0, reset_in = 1, reg_wr_in = 0, reg_rd_in = 0;
   logic [`CSO_ADDR_W-1:0] reg_addr_in = '0;
   logic [7:0]             reg_wdata_in = '0, reg_rdata_out, exp_ctrl, got;
   logic                   reg_rvalid_out, ref_thresh_sel_out, first_output_cmos_out;
   logic                   clk_above_thresh_in = 0, first_ref_above_thresh_in = 0;
   logic                   second_ref_above_thresh_in = 0, pll_digital_lock_in = 0;
   logic                   first_output_leg_a_on_out, first_output_leg_b_on_out;
   logic [1:0]             first_output_polarity_out, first_output_lvds_swing_out;
   logic                   first_output_power_down_out;
   logic [31:0]            seed = 32'h2ef3;
   logic [7:0]             exp_q[$];
   int                     err_count = 0, n_checks = 0;

   cso_regs DUT (.*);

   // Free-running 50 MHz clock
   always #10 clk_in = ~clk_in;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Strobes drop a cycle later, so no two requests share an edge
   task automatic wr(input logic [`CSO_ADDR_W-1:0] a, input logic [7:0] d);
      @(negedge clk_in);
      reg_wr_in = 1;
      reg_addr_in = a;
      reg_wdata_in = d;
      @(negedge clk_in);
      reg_wr_in = 0;
   endtask

   task automatic rd(input logic [`CSO_ADDR_W-1:0] a, output logic [7:0] d);
      @(negedge clk_in);
      reg_rd_in = 1;
      reg_addr_in = a;
      @(negedge clk_in);
      reg_rd_in = 0;
      chk("rvalid", 8'h01, {7'h00, reg_rvalid_out});
      d = reg_rdata_out;
   endtask

   // Output pins and readback against the modelled control byte
   task automatic check_outs;
      logic [7:0] legs;
      legs = exp_ctrl[7] ? {6'h00, exp_ctrl[6:5]} : 8'h03;
      chk("cmos", {7'h00, exp_ctrl[7]}, {7'h00, first_output_cmos_out});
      chk("legs", legs, {6'h00, first_output_leg_b_on_out, first_output_leg_a_on_out});
      chk("low", {3'h0, exp_ctrl[4:0]}, {3'h0, first_output_polarity_out,
          first_output_lvds_swing_out, first_output_power_down_out});
      rd(`CSO_ADDR_DRV_CTRL, got);
      chk("ctrl", exp_ctrl, got);
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial
   begin
      // Six full rising edges under reset, release off the edge
      repeat (6) @(posedge clk_in);
      @(negedge clk_in);
      reset_in = 0;
      exp_ctrl = 8'h62;
      check_outs;
      chk("thresh", 8'h00, {7'h00, ref_thresh_sel_out});
      $display("test reset done");
      // Random monitor levels, some with a stray write to status
      repeat (16)
      begin
         seed = xs(seed);
         {clk_above_thresh_in, second_ref_above_thresh_in, first_ref_above_thresh_in,
          pll_digital_lock_in} = seed[3:0];
         exp_q.push_back({4'h0, seed[3:0]});
         if (seed[4])
            wr(`CSO_ADDR_STATUS, seed[15:8]);
         rd(`CSO_ADDR_STATUS, got);
         chk("status", exp_q.pop_front(), got);
      end
      $display("test status done");
      // All ones first, then clear, then bit 6 alone
      for (int i = 0; i < 3; i++)
      begin
         exp_ctrl = i == 1 ? 8'h00 : 8'h40;
         wr(`CSO_ADDR_THRESH_CFG, i == 0 ? 8'hff : exp_ctrl);
         chk("thresh", {7'h00, exp_ctrl[6]}, {7'h00, ref_thresh_sel_out});
         rd(`CSO_ADDR_THRESH_CFG, got);
         chk("cfg", exp_ctrl, got);
      end
      $display("test threshold done");
      // Every format and leg code, random low fields
      for (int i = 0; i < 8; i++)
      begin
         seed = xs(seed);
         exp_ctrl = {i[2:0], seed[4:0]};
         wr(`CSO_ADDR_DRV_CTRL, exp_ctrl);
         @(negedge clk_in);
         check_outs;
      end
      wr(10'h3ff, 8'hff);
      rd(10'h3ff, got);
      chk("unmapped", 8'h00, got);
      check_outs;
      $display("test format done");
      end_of_test;
   end

   // Whole run is a little over a hundred cycles
   initial
   begin
      #(3000 * 20);
      err_count++;
      end_of_test;
   end
endmodule

// ### cso_status_mon.sv
`timescale 1ns/1ps
`include "cso_map.svh"

// ----------------------------------------------------------------
// Frequency monitor and lock status capture
// ----------------------------------------------------------------
module cso_status_mon
   import cso_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic reset_in,
   input  wire logic clk_above_thresh_in,
   input  wire logic first_ref_above_thresh_in,
   input  wire logic second_ref_above_thresh_in,
   input  wire logic pll_digital_lock_in,
   cso_mon_if.mon    mon
);

   cso_status_type status_r;

   // Capture monitor levels every cycle; a read sees the state sampled one edge earlier
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         status_r <= '0;
      end
      else
      begin
         status_r.clk_above        <= clk_above_thresh_in;
         status_r.second_ref_above <= second_ref_above_thresh_in;
         status_r.first_ref_above  <= first_ref_above_thresh_in;
         status_r.digital_lock     <= pll_digital_lock_in;
      end
   end

   assign mon.status = status_r;

endmodule
